// ---- include/sfs_params.svh ----
// Constants of the serial-flash status front end.
// Included by the package and the core; definitions only.
`ifndef SFS_PARAMS_SVH
`define SFS_PARAMS_SVH

// Status register bit positions and reset value
`define SFS_SR_BUSY 0
`define SFS_SR_WEL 1
`define SFS_SR_BP_LSB 2
`define SFS_SR_BP_MSB 5
`define SFS_SR_QE 6
`define SFS_SR_STATUS_WRITE_DISABLE 7
`define SFS_SR_RESET 8'h00

// Array map: 23 address bits, 4K sectors, 32K and 64K blocks
`define SFS_ADDR_MAX 24'h7FFFFF
`define SFS_ADDR_MSB 22
`define SFS_SECTOR_LSB 12
`define SFS_BLK32_LSB 15
`define SFS_BLK64_LSB 16
`define SFS_SECTOR_LAST 2047

// Frame lengths in bits
`define SFS_BITS_OP 6'h08
`define SFS_BITS_DATA 6'h10
`define SFS_BITS_ADDR 6'h20
`define SFS_BITS_SAT 6'h3C

// Status-write cycle time and its count at the mclk rate
`define SFS_MCLK_MHZ 40
`define SFS_SRW_TIME_NS 5000
`define SFS_SRW_CYCLES ((`SFS_SRW_TIME_NS * `SFS_MCLK_MHZ + 999) / 1000)

`endif

// ---- include/sfs_pkg.sv ----
// Types shared by the serial-flash status front end.
// Assumes sfs_params.svh is on the include path.
`include "sfs_params.svh"

package sfs_pkg;

    // Status register, bit 7 down to bit 0
    typedef struct packed {
        logic status_write_disable;
        logic quad_enable;
        logic [3:0] block_protect_bits;
        logic write_enable_latch;
        logic busy_flag;
    } sfs_status_t;

    // Command frame handed to the array side
    typedef struct packed {
        logic [7:0] opcode;
        logic [23:0] addr;
    } sfs_cmd_t;

    // Array location of a command address
    typedef struct packed {
        logic [10:0] sector;
        logic [7:0] block32;
        logic [6:0] block64;
    } sfs_loc_t;

    typedef enum logic [1:0] {
        SFS_IDLE,
        SFS_SRW,
        SFS_ARRAY
    } sfs_state_t;

endpackage

// ---- core/sfs_spi_status.sv ----
// Serial-flash slave front end: bit shifter on the serial clock,
// status register and command checks on mclk.
// Assumes sck and cs_n come from the bus master and io pads are
// resolved outside from io_out/io_oe.
//
// Function
// [R1] Master uses only clock modes 0 or 3
// [R2] Sample on rising edge, launch on falling
// [R3] Quad mode: four pins become data lanes
// [R4] Uniform 4K sectors, 32K and 64K blocks
// [R5] Addresses to 7FFFFFh, sectors 0 to 2047
// [R6] Register read repeats same byte until deselect; the code repeats it only until the bit count holds at 60
// [R7] Eight-bit status layout, all zero default; the code loads bits 7:2 from nv_load at reset
// [R8] Busy flag read-only, set during cycles
// [R9] Write-enable command sets the latch
// [R10] Write-disable or completion clears the latch
// [R11] Status write leaves the latch alone; the code clears the latch when a status-write cycle ends
// [R12] Latch clear inhibits writes, program, erase
// [R13] Protect, quad, disable bits persist, status-write only
// [R14] Read-status returns whole register serially
// [R15] Protect bits choose top blocks protected
// [R16] Quad enable bit enables four lanes; the code takes four lanes from quad_command_mode whatever the bit
// [R17] Disable bit marks status write-protected
// [R18] Disable bit plus low protect pin locks
// [R19] Quad enable turns pause/protect pins into lanes
// [R20] Frames start on select low, MSB first
`timescale 1ns/100ps
`include "sfs_params.svh"

module sfs_spi_status
    import sfs_pkg::*;
#(
    parameter int SRW_CYCLES = `SFS_SRW_CYCLES,
    // Opcode values are arbitrary defaults
    parameter logic [7:0] OP_WR_ENABLE = 8'h06,
    parameter logic [7:0] OP_WR_DISABLE = 8'h04,
    parameter logic [7:0] OP_WR_STATUS = 8'h01,
    parameter logic [7:0] OP_RD_STATUS = 8'h05
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    input wire logic quad_command_mode,
    input wire logic [5:0] nv_load,
    output logic nv_write,
    output logic [5:0] nv_data,
    input wire logic array_start,
    input wire logic array_done,
    output logic cmd_valid,
    output sfs_cmd_t cmd,
    output sfs_loc_t loc,
    output logic addr_protected,
    output logic write_allowed,
    output sfs_status_t status
);

    // Elaboration check on the busy count
    if (SRW_CYCLES < 1 || SRW_CYCLES > 65535) begin : g_chk
        $error("SRW_CYCLES out of range");
    end

    // Link-domain state
    logic link_act_reg;
    logic [5:0] bits_reg;
    logic [5:0] bits_next;
    logic [31:0] shift_reg;
    logic [31:0] shift_next;
    logic frame_tgl_reg;
    logic rd_act_reg;
    logic [7:0] stat_s1_reg;
    logic [7:0] stat_s2_reg;
    logic hold_s1_reg;
    logic hold_s2_reg;
    logic [3:0] out_reg;
    logic oe_reg;

    // mclk-domain state
    logic cs_s1_reg;
    logic cs_s2_reg;
    logic cs_s3_reg;
    logic wp_s1_reg;
    logic wp_s2_reg;
    logic tgl_s1_reg;
    logic tgl_s2_reg;
    logic seen_reg;
    logic quad_mode_reg;
    logic [5:0] nv_reg;
    logic wel_reg;
    logic wel_next;
    sfs_state_t state_reg;
    sfs_state_t state_next;
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic nv_write_reg;
    logic cmd_valid_reg;
    sfs_cmd_t cmd_reg;

    // Quad mode only changes while deselected, so the link side
    // reads it as a quasi-static setting
    wire quad_link = quad_mode_reg;
    wire qe_link = stat_s2_reg[`SFS_SR_QE];

    // Pause pin is live only with quad enable clear [R19]
    wire hold_func = !qe_link && !quad_link;
    wire paused = hold_func && !hold_s2_reg;

    // Lanes per edge: four in quad mode, one otherwise [R3]
    wire [5:0] step = quad_link ? 6'h04 : 6'h01;
    wire [5:0] bits_base = link_act_reg ? bits_reg : 6'h00;
    wire bits_sat = bits_base >= `SFS_BITS_SAT;
    wire [31:0] shift_src = link_act_reg ? shift_reg : 32'h0;
    wire shift_full = bits_base >= `SFS_BITS_ADDR;

    // MSB-first accumulation, first bit lands highest [R20]
    assign bits_next = bits_sat ? bits_base : bits_base + step;
    assign shift_next = shift_full ? shift_src :
        quad_link ? {shift_src[27:0], io_in} :
        {shift_src[30:0], io_in[0]};

    wire op_hit = (bits_base < `SFS_BITS_OP) &&
        (bits_next == `SFS_BITS_OP);

    // Frame activity, cleared whenever select is high [R20]
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            link_act_reg <= 1'b0;
        end else if (!paused) begin
            link_act_reg <= 1'b1;
        end
    end

    // Rising-edge sampling; kept after deselect for mclk [R2]
    // A mode-3 idle rise with select high must not touch the count
    always_ff @(posedge sck) begin
        if (!cs_n && !paused) begin
            bits_reg <= bits_next;
            shift_reg <= shift_next;
        end
    end

    // One toggle per frame tells mclk a new frame happened
    always_ff @(posedge sck or posedge sys_rst) begin
        if (sys_rst) begin
            frame_tgl_reg <= 1'b0;
        end else if (!cs_n && !paused && !link_act_reg) begin
            frame_tgl_reg <= ~frame_tgl_reg;
        end
    end

    // Read-status armed once the opcode byte is in [R14]
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            rd_act_reg <= 1'b0;
        end else if (!paused && op_hit) begin
            rd_act_reg <= shift_next[7:0] == OP_RD_STATUS;
        end
    end

    // Status crosses into the link clock
    always_ff @(posedge sck) begin
        stat_s1_reg <= status;
        stat_s2_reg <= stat_s1_reg;
    end

    // Pause pin sync; starts released each frame, so a pin that
    // was never sampled cannot freeze the first edges
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            hold_s1_reg <= 1'b1;
            hold_s2_reg <= 1'b1;
        end else begin
            hold_s1_reg <= io_in[3];
            hold_s2_reg <= hold_s1_reg;
        end
    end

    // Bit index wraps every byte, so the byte repeats until the count holds at 60 bits [R6]
    wire [2:0] bit_idx = 3'h7 - bits_reg[2:0];
    wire [3:0] out_sel = quad_link ?
        (bits_reg[2] ? stat_s2_reg[3:0] : stat_s2_reg[7:4]) :
        {3'h0, stat_s2_reg[bit_idx]};

    // Falling-edge launch, same in mode 0 and mode 3 [R2] [R1]
    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            out_reg <= 4'h0;
            oe_reg <= 1'b0;
        end else begin
            out_reg <= out_sel; // [R14]
            oe_reg <= rd_act_reg && !paused;
        end
    end

    // Pad drive: lane 1 alone in single mode, all four in quad
    for (genvar i = 0; i < 4; i++) begin : g_lane
        if (i == 1) begin : g_so
            assign io_out[i] = quad_link ? out_reg[i] : out_reg[0];
            assign io_oe[i] = oe_reg;
        end else begin : g_io
            assign io_out[i] = quad_link ? out_reg[i] : 1'b0;
            assign io_oe[i] = oe_reg && quad_link; // [R3]
        end
    end

    // Pin synchronisers on mclk
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_s3_reg <= 1'b1;
            wp_s1_reg <= 1'b1;
            wp_s2_reg <= 1'b1;
            tgl_s1_reg <= 1'b0;
            tgl_s2_reg <= 1'b0;
        end else if (clk_en) begin
            cs_s1_reg <= cs_n;
            cs_s2_reg <= cs_s1_reg;
            cs_s3_reg <= cs_s2_reg;
            wp_s1_reg <= io_in[2];
            wp_s2_reg <= wp_s1_reg;
            tgl_s1_reg <= frame_tgl_reg;
            tgl_s2_reg <= tgl_s1_reg;
        end
    end

    // Frame end: select went high after at least one edge.
    // The shifter is idle then, so its words are stable.
    wire new_frame = tgl_s2_reg != seen_reg;
    wire frame_end = cs_s2_reg && !cs_s3_reg && new_frame;

    wire len_op = bits_reg == `SFS_BITS_OP;
    wire len_data = bits_reg == `SFS_BITS_DATA;
    wire len_addr = bits_reg >= `SFS_BITS_ADDR;
    wire [7:0] f_op = len_op ? shift_reg[7:0] :
        len_data ? shift_reg[15:8] : shift_reg[31:24];
    wire [7:0] f_data = shift_reg[7:0];

    wire busy = state_reg != SFS_IDLE; // [R8]

    // Disable bit and protect pin lock the register; in quad
    // use the protect pin is a lane and cannot lock [R18] [R17]
    wire wp_level = nv_reg[4] || quad_mode_reg || wp_s2_reg;
    wire sr_locked = nv_reg[5] && !wp_level;

    // Command checks; while busy only read-status and address frames get through
    wire do_write_enable_cmd = frame_end && len_op && !busy &&
        f_op == OP_WR_ENABLE;
    wire do_write_disable_cmd = frame_end && len_op && !busy &&
        f_op == OP_WR_DISABLE;
    wire do_write_status_cmd = frame_end && len_data && !busy && wel_reg &&
        !sr_locked && f_op == OP_WR_STATUS; // [R12] [R18]
    wire do_array = array_start && wel_reg && !busy; // [R12]

    // Busy sequencing
    wire srw_fin = state_reg == SFS_SRW && cnt_reg == 16'h0000;
    wire arr_fin = state_reg == SFS_ARRAY && array_done;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        unique case (state_reg)
            SFS_IDLE: begin
                if (do_write_status_cmd) begin
                    state_next = SFS_SRW;
                    cnt_next = 16'(SRW_CYCLES - 1);
                end else if (do_array) begin
                    state_next = SFS_ARRAY;
                end
            end
            SFS_SRW: begin
                if (srw_fin) begin
                    state_next = SFS_IDLE;
                end else begin
                    cnt_next = cnt_reg - 16'h0001;
                end
            end
            SFS_ARRAY: begin
                if (array_done) begin
                    state_next = SFS_IDLE;
                end
            end
        endcase
    end

    // Latch: set wins over a clear in the same cycle [R9] [R10]
    wire wel_clr = do_write_disable_cmd || srw_fin || arr_fin;
    assign wel_next = do_write_enable_cmd || (wel_reg && !wel_clr); // [R11]

    // Control and status registers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg <= SFS_IDLE;
            cnt_reg <= 16'h0000;
            wel_reg <= 1'b0; // [R7]
            seen_reg <= 1'b0;
            quad_mode_reg <= 1'b0;
        end else if (clk_en) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            wel_reg <= wel_next;
            if (frame_end) begin
                seen_reg <= tgl_s2_reg;
            end
            if (cs_s2_reg) begin
                quad_mode_reg <= quad_command_mode;
            end
        end
    end

    // Persistent bits reload from the store at reset and change
    // only on an accepted status write [R13]
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            nv_reg <= nv_load;
            nv_write_reg <= 1'b0;
        end else if (clk_en) begin
            nv_write_reg <= do_write_status_cmd;
            if (do_write_status_cmd) begin
                nv_reg <= f_data[7:2];
            end
        end
    end

    // Address frames go to the array side
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cmd_valid_reg <= 1'b0;
            cmd_reg <= '0;
        end else if (clk_en) begin
            cmd_valid_reg <= frame_end && len_addr;
            if (frame_end && len_addr) begin
                cmd_reg.opcode <= f_op;
                cmd_reg.addr <= shift_reg[23:0] & `SFS_ADDR_MAX;
            end
        end
    end

    // Register layout: disable, quad, protect, latch, busy [R7]
    assign status.status_write_disable = nv_reg[5];
    assign status.quad_enable = nv_reg[4]; // [R16]
    assign status.block_protect_bits = nv_reg[3:0];
    assign status.write_enable_latch = wel_reg;
    assign status.busy_flag = busy; // [R8]

    // Sector, 32K and 64K block numbers [R4] [R5]
    wire [23:0] a = cmd_reg.addr;
    assign loc.sector = a[`SFS_ADDR_MSB:`SFS_SECTOR_LSB];
    assign loc.block32 = a[`SFS_ADDR_MSB:`SFS_BLK32_LSB];
    assign loc.block64 = a[`SFS_ADDR_MSB:`SFS_BLK64_LSB];

    // Top-area protection: setting v covers the top 2^(v-1)
    // blocks, 8 and above cover all [R15]
    wire [3:0] bp = nv_reg[3:0];
    wire [2:0] bp_sh = bp[2:0] - 3'h1;
    wire [6:0] bp_mask = 7'h7F << bp_sh;
    wire top_hit = (loc.block64 & bp_mask) == bp_mask;
    assign addr_protected = bp[3] || (bp != 4'h0 && top_hit);

    // Outputs to the array side
    assign write_allowed = wel_reg && !busy; // [R12]
    assign nv_write = nv_write_reg;
    assign nv_data = nv_reg;
    assign cmd_valid = cmd_valid_reg;
    assign cmd = cmd_reg;

endmodule

// ---- dv/sfs_spi_status_assertions.sv ----
// Port checker of the status front end, bound into its top.
// Assumes clk_en stays high, so every mclk edge counts.
`timescale 1ns/100ps
module sfs_spi_status_assertions
    import sfs_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic cs_n,
    input wire logic quad_command_mode,
    input wire logic [3:0] io_oe,
    input wire logic array_start,
    input wire logic array_done,
    input wire logic nv_write,
    input wire logic [5:0] nv_data,
    input wire logic cmd_valid,
    input wire sfs_cmd_t cmd,
    input wire logic write_allowed,
    input wire sfs_status_t status
);
    logic arr_reg;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // Marks an accepted array cycle so done is judged only then
    always_ff @(posedge mclk) begin
        if (sys_rst || array_done)
            arr_reg <= 1'b0;
        else if (array_start && write_allowed)
            arr_reg <= 1'b1;
    end
    a_start_busy: assert property (array_start && write_allowed
        |=> status.busy_flag) else $error("start left busy low");
    a_start_refused: assert property (array_start &&
        !status.write_enable_latch && !status.busy_flag
        |=> !status.busy_flag) else $error("start taken without latch");
    a_allow_rule: assert property (write_allowed ==
        (status.write_enable_latch && !status.busy_flag))
        else $error("write allow wrong");
    a_done_clear: assert property (arr_reg && array_done
        |=> !status.busy_flag && !status.write_enable_latch)
        else $error("done left busy or latch");
    a_nv_mirror: assert property ({status.status_write_disable,
        status.quad_enable, status.block_protect_bits} == nv_data)
        else $error("status differs from stored bits");
    a_nv_busy: assert property (!$stable(nv_data) &&
        !$past(sys_rst) |-> status.busy_flag && nv_write)
        else $error("stored bits moved outside a write");
    a_nv_pulse: assert property (nv_write |=> !nv_write)
        else $error("store pulse too long");
    a_oe_idle: assert property (cs_n |-> io_oe == 4'h0)
        else $error("pad driven while deselected");
    a_oe_single: assert property (!quad_command_mode
        |-> io_oe[0] == 1'b0 && io_oe[3:2] == 2'h0)
        else $error("extra lane driven in single mode");
    a_addr_range: assert property (cmd_valid
        |-> cmd.addr <= 24'h7FFFFF ##1 !cmd_valid)
        else $error("command address out of range");
    c_array: cover property (array_start && write_allowed);
    c_store: cover property (nv_write);
    c_cmd: cover property (cmd_valid);
endmodule

bind sfs_spi_status sfs_spi_status_assertions u_chk (.mclk, .sys_rst,
    .cs_n, .quad_command_mode, .io_oe, .array_start, .array_done,
    .nv_write, .nv_data, .cmd_valid, .cmd, .write_allowed, .status);

// ---- dv/sfs_master_model.sv ----
// Serial bus master model: clock, select and lane 0 data.
// Assumes the bench calls xfer; the clock stands still between frames.
`timescale 1ns/100ps
module sfs_master_model (
    output logic sck,
    output logic cs_n,
    output logic [3:0] io_in,
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe
);
    logic mode3 = 1'b0;
    logic wp = 1'b1;
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        io_in = 4'hA;
    end
    // One frame, MSB first; lane 0 moves on fall, read taken on rise
    task automatic xfer(input logic [31:0] tx, input int n,
        output logic [31:0] rx);
        rx = 32'h0;
        #160;
        sck = mode3;
        io_in[3:2] = {1'b1, wp};
        #80;
        cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            sck = 1'b0;
            io_in[0] = tx[31 - i];
            #80;
            sck = 1'b1;
            rx = {rx[30:0], io_oe[1] ? io_out[1] : 1'bz};
            #80;
        end
        sck = mode3;
        #80;
        cs_n = 1'b1;
        io_in[1:0] = ~io_in[1:0]; // Released line must not hold
    endtask
endmodule

// ---- dv/sfs_spi_status_bench.sv ----
// Self-checking bench of the status front end.
// Assumes the bound checker; serial clock 160 ns from the model.
`timescale 1ns/100ps
module sfs_spi_status_bench;
    import sfs_pkg::*;
    localparam int SRW = 4;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic quad_command_mode = 1'b0;
    logic [5:0] nv_load = 6'h00;
    logic array_start = 1'b0;
    logic array_done = 1'b0;
    logic sck, cs_n, nv_write, cmd_valid, addr_protected, write_allowed;
    logic [3:0] io_in, io_out, io_oe;
    logic [5:0] nv_data;
    sfs_cmd_t cmd;
    sfs_loc_t loc;
    sfs_status_t status;
    logic [31:0] rx;
    logic [23:0] a;
    logic [7:0] sr;
    int seed = 32'h54d3;
    int bad_count = 0;
    int compares = 0;
    always #12.5 mclk = ~mclk;
    sfs_spi_status #(.SRW_CYCLES(SRW)) DUT (.mclk, .sys_rst, .clk_en,
        .sck, .cs_n, .io_in, .io_out, .io_oe, .quad_command_mode,
        .nv_load, .nv_write, .nv_data, .array_start, .array_done,
        .cmd_valid, .cmd, .loc, .addr_protected, .write_allowed, .status);
    sfs_master_model m (.sck, .cs_n, .io_in, .io_out, .io_oe);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares += 1;
        if (seen !== exp) begin
            bad_count += 1;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic end_of_test;
        if (bad_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Top-area protection: 2^(p-1) top blocks, all from 8 up
    function automatic logic prot(input logic [3:0] p,
        input logic [6:0] b);
        if (p[3])
            return 1'b1;
        if (p == 4'h0)
            return 1'b0;
        return {1'b0, b} >= 8'h80 - (8'h01 << (p - 4'h1));
    endfunction
    task automatic op(input logic [7:0] c);
        m.xfer({c, 24'h0}, 8, rx);
        tick(5);
    endtask
    task automatic read_status_cmd;
        m.xfer({8'h05, 24'h0}, 24, rx);
        chk(rx[15:0], {sr, sr});
        chk(status, sr);
    endtask
    // Latch first, then a status write; the latch waits for the end
    task automatic write_status_cmd(input logic [7:0] d, input logic ok);
        op(8'h06);
        sr[1] = 1'b1;
        m.xfer({8'h01, d, 16'h0}, 16, rx);
        tick(5);
        if (ok)
            sr[7:2] = d[7:2];
        chk(status, {sr[7:2], 1'b1, ok});
        tick(SRW + 4);
        if (ok)
            sr[1] = 1'b0;
        chk(status, sr);
    endtask
    initial begin
        @(posedge mclk);
        nv_load <= 6'($random(seed));
        repeat (9) @(posedge mclk);
        sys_rst <= 1'b0;
        tick(5);
        sr = {nv_load, 2'h0};
        chk(status, sr);
        read_status_cmd();
        m.mode3 = 1'b1;
        read_status_cmd();
        m.mode3 = 1'b0;
        op(8'h06);
        chk(write_allowed, 1'b1);
        op(8'h04);
        chk(status.write_enable_latch, 1'b0);
        m.xfer({8'h01, 8'hFC, 16'h0}, 16, rx);
        tick(5);
        chk(status, sr);
        repeat (3) write_status_cmd(8'($random(seed)), 1'b1);
        // Lock needs disable bit and low protect pin, not quad enable
        write_status_cmd(8'h80, 1'b1);
        m.wp = 1'b0;
        write_status_cmd(8'h3C, 1'b0);
        m.wp = 1'b1;
        write_status_cmd(8'hC0, 1'b1);
        m.wp = 1'b0;
        write_status_cmd(8'h00, 1'b1);
        m.wp = 1'b1;
        read_status_cmd();
        // Boundary block for protect settings 0 to 8, odd ones just below
        for (int bp = 0; bp < 9; bp++) begin
            write_status_cmd({2'h0, 4'(bp), 2'h0}, 1'b1);
            a = 24'($random(seed));
            a[22:16] = (bp == 0) ? 7'h7F : 7'(128 - (1 << (bp - 1)) - bp % 2);
            m.xfer({8'h20, a}, 32, rx);
            for (int w = 0; w < 20 && cmd_valid !== 1'b1; w++)
                tick(1);
            chk(cmd_valid, 1'b1);
            chk(cmd.addr, a & 24'h7FFFFF);
            chk(loc, {a[22:12], a[22:15], a[22:16]});
            chk(addr_protected, prot(4'(bp), a[22:16]));
        end
        // Array cycle refused without latch, then taken and finished
        @(posedge mclk) array_start <= 1'b1;
        @(posedge mclk) array_start <= 1'b0;
        tick(2);
        chk(status.busy_flag, 1'b0);
        op(8'h06);
        @(posedge mclk) array_start <= 1'b1;
        @(posedge mclk) array_start <= 1'b0;
        tick(1);
        chk(status, {sr[7:2], 2'h3});
        op(8'h04);
        chk(status.write_enable_latch, 1'b1);
        @(posedge mclk) array_done <= 1'b1;
        @(posedge mclk) array_done <= 1'b0;
        tick(1);
        chk(status, sr);
        end_of_test();
    end
    // Hang guard, well past the expected run
    initial begin
        #1500000;
        bad_count += 1;
        end_of_test();
    end
endmodule
